// [shared/bis_pkg.sv]
// constants, types and register map of the burner ignition and run sequencer
package bis_pkg;

    // ----------------------------------------------------------------
    // clock and seconds tick
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned SEC_TICK_S = 1;
    localparam int unsigned SEC_TICK_CYCLES = CLK_HZ * SEC_TICK_S;

    // ----------------------------------------------------------------
    // sequence times in whole seconds
    // ----------------------------------------------------------------
    localparam logic [7:0] T_PILOT_LONG_S = 8'h0a;
    localparam logic [7:0] T_PILOT_SHORT_S = 8'h04;
    localparam logic [7:0] T_SPARK_OFF_S = 8'h05;
    localparam logic [7:0] T_TEST_LIM_LONG_S = 8'h08;
    localparam logic [7:0] T_TEST_LIM_SHORT_S = 8'h03;
    localparam logic [7:0] T_FLAMEOUT_S = 8'h0f;
    localparam logic [7:0] T_IGN_OFF_S = 8'h0a;
    localparam logic [7:0] T_PILOT_INT_S = 8'h0f;
    localparam logic [7:0] T_PILOT_INT_EXT_S = 8'h1e;
    localparam logic [7:0] T_STAB_S = 8'h0a;
    localparam logic [7:0] T_POSTPURGE_S = 8'h0f;
    localparam logic [7:0] T_PREIGN_CLOSE_S = 8'h05;
    localparam logic [7:0] T_PREEMPT_S = 8'h3c;
    localparam logic [7:0] SEC_MAX = 8'hff;

    // ----------------------------------------------------------------
    // register map (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MSG = 8'h08;
    localparam int CTRL_VAR_LSB = 0;
    localparam int CTRL_RST_BIT = 2;
    localparam int CTRL_PURGE_LSB = 8;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_LOCK_BIT = 4;
    localparam int STAT_PREEMPT_BIT = 5;
    localparam int STAT_HOLD_BIT = 6;
    localparam int STAT_OUT_LSB = 8;
    localparam logic [7:0] PURGE_RST = 8'h1e;
    localparam logic [7:0] MSG_RST = 8'h00;

    // product variants
    typedef enum logic [1:0] {
        VAR_LOCKOUT,
        VAR_CONFIG,
        VAR_INTERMIT_MOD,
        VAR_ONOFF
    } bis_variant_t;

    localparam bis_variant_t VAR_RST = VAR_LOCKOUT;

    // sequence states
    typedef enum logic [3:0] {
        ST_STANDBY,
        ST_PP_HIGH,
        ST_PP_TIMED,
        ST_PP_LOW,
        ST_PILOT,
        ST_MAIN,
        ST_RUN,
        ST_POSTPURGE,
        ST_LOCKOUT
    } bis_state_t;

endpackage : bis_pkg

// [verif/bis_field.sv]
// field model: firing-rate switches and flame amplifier
`timescale 1ns/10ps
module bis_field (
    input wire logic clock_i,
    input wire logic fr_high_o,
    input wire logic fr_low_o,
    input wire logic pilot_valve_o,
    input wire logic main_valve_o,
    input wire logic flame_en_i,
    input wire logic open_low_i,
    output logic high_fire_sw_i,
    output logic low_fire_sw_i,
    output logic flame_i
);
    logic [1:0] hi_r = 2'h0, lo_r = 2'h0;
    logic fl_r = 1'h0;
    // motor travel and flame sensing lag, so no loop through the fault logic
    always @(posedge clock_i) begin
        hi_r <= {hi_r[0], fr_high_o};
        lo_r <= {lo_r[0], fr_low_o & !fr_high_o};
        fl_r <= flame_en_i & (pilot_valve_o | main_valve_o);
    end
    assign high_fire_sw_i = hi_r[1];
    assign low_fire_sw_i = lo_r[1] & !open_low_i;
    assign flame_i = fl_r;
endmodule : bis_field

// [verif/bis_sva.sv]
// port-level assertions for the burner sequencer
`timescale 1ns/10ps
module bis_sva (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic low_fire_sw_i,
    input wire logic flame_i,
    input wire logic pilot_valve_o,
    input wire logic pilot_ign_o,
    input wire logic spark_o,
    input wire logic main_valve_o,
    input wire logic blower_o,
    input wire logic fr_low_o,
    input wire logic fr_release_o,
    input wire logic lockout_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    a_ack_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer timing");
    a_pilot_start: assert property ($rose(pilot_ign_o) |-> pilot_valve_o && spark_o && fr_low_o)
        else $error("pilot start outputs");
    a_lowfire_trip: assert property (pilot_ign_o |-> low_fire_sw_i)
        else $error("ignition with low fire open");
    a_main_flame: assert property ($rose(main_valve_o) |-> $past(flame_i) && !spark_o && pilot_valve_o)
        else $error("main valve opened wrongly");
    a_lock_quiet: assert property (lockout_o |-> !(pilot_valve_o || pilot_ign_o || spark_o || main_valve_o))
        else $error("fuel output in lockout");
    a_lock_held: assert property ($fell(lockout_o) |-> $past(wb_stb_i && wb_we_i) || $past(wb_stb_i, 2))
        else $error("lockout left without write");
    a_release_main: assert property ($rose(fr_release_o) |-> main_valve_o && $past(main_valve_o, 8))
        else $error("release without stable flame");
    a_post_start: assert property ($fell(main_valve_o) |=> lockout_o || (blower_o && fr_low_o))
        else $error("postpurge start outputs");
endmodule : bis_sva
bind bis_sequencer bis_sva i_sva (.*);

// [verif/tb.sv]
// self-checking bench for the burner sequencer
`timescale 1ns/10ps
module tb;
    import bis_pkg::*;
    logic clock_i = 1'h0, sys_rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic demand_i = 1'h0, pilot_period_jumper_i = 1'h0, flame_en_i = 1'h1, open_low_i = 1'h0;
    logic preign_ilk_i = 1'h1, test_sw_i = 1'h0, pilot_valve_mode_jumper_i = 1'h0;
    logic blower_wire_i = 1'h0, valve_term_jumpered_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, rd;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, pilot_valve_o, pilot_ign_o, spark_o, main_valve_o, blower_o, fr_high_o, fr_low_o;
    wire fr_release_o, damper_o, lockout_o, display_preempt_o, high_fire_sw_i, low_fire_sw_i, flame_i;
    wire [4:0] o = {fr_release_o | damper_o, lockout_o, blower_o, pilot_ign_o, main_valve_o};
    int errors = 0, checked = 0, n;
    bis_sequencer #(.TICK_CYCLES(2)) i_dut (.*);
    bis_field i_field (.*);
    initial forever #2.5 clock_i = ~clock_i;
    task automatic chk(input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rng(input int got, lo, hi);
        checked++;
        if (got < lo || got > hi) begin
            errors++;
            $display("mismatch %0t span %0d", $time, got);
        end
    endtask : rng
    // one bus cycle, held until ack is seen at an edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, 4'hf, d};
        do @(posedge clock_i); while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_sel_i} <= 6'h00;
    endtask : wb
    // count edges until a watched output takes a level
    task automatic wt(input int i, input logic v);
        n = 0;
        while (o[i] !== v) begin
            @(posedge clock_i);
            n++;
        end
    endtask : wt
    task automatic s_regs;
        wb(1'h0, REG_CTRL, 32'h0000_0000);
        chk(rd, {16'h0000, PURGE_RST, 8'h00});
        wb(1'h1, REG_STATUS, 32'hffff_ffff);
        wb(1'h0, REG_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        wb(1'h0, 8'h0c, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        wb(1'h1, REG_MSG, 32'h0000_005a);
        wb(1'h0, REG_MSG, 32'h0000_0000);
        chk(rd, 32'h0000_005a);
    endtask : s_regs
    // a whole firing cycle; m is the main period in seconds, p whether the pilot stays in run
    // two cycles a tick: ignition off at 10 s, main ends at m s, then 10 s stabilization, so 2*m cycles
    task automatic s_fire(input logic [1:0] v, input int m, input logic p);
        wb(1'h1, REG_CTRL, {16'h0000, 8'h02, 6'h00, v});
        demand_i <= 1'h1;
        wt(0, 1'h1);
        wt(1, 1'h0);
        rng(n, 17, 23);
        wt(4, 1'h1);
        rng(n, 2 * m - 3, 2 * m + 3);
        chk(pilot_valve_o, p);
        chk(damper_o, v == 2'h3);
        chk(fr_release_o, v != 2'h3);
        test_sw_i <= 1'h1;
        repeat (3) @(posedge clock_i);
        chk({fr_low_o, fr_release_o}, 2'h2);
        test_sw_i <= 1'h0;
        demand_i <= 1'h0;
        wt(0, 1'h0);
        #1 chk({blower_o, fr_low_o, pilot_valve_o}, 3'h6);
        wt(2, 1'h0);
        rng(n, 27, 33);
    endtask : s_fire
    // no flame at a short pilot period, then a low-fire trip
    task automatic s_faults;
        flame_en_i <= 1'h0;
        pilot_period_jumper_i <= 1'h1;
        demand_i <= 1'h1;
        wt(1, 1'h1);
        wt(3, 1'h1);
        rng(n, 6, 10);
        wb(1'h1, REG_CTRL, 32'h0000_0204);
        flame_en_i <= 1'h1;
        wt(1, 1'h1);
        open_low_i <= 1'h1;
        #1 chk({pilot_valve_o, spark_o, pilot_ign_o}, 3'h0);
        repeat (20) @(posedge clock_i);
        chk(lockout_o, 1'h1);
        demand_i <= 1'h0;
        open_low_i <= 1'h0;
        wb(1'h1, REG_CTRL, 32'h0000_0204);
        #1 chk(lockout_o, 1'h0);
    endtask : s_faults
    // test holds in prepurge and pilot, message preemption, flameout guard
    task automatic s_test;
        test_sw_i <= 1'h1;
        demand_i <= 1'h1;
        repeat (100) @(posedge clock_i);
        chk(display_preempt_o, 1'h0);
        repeat (40) @(posedge clock_i);
        chk(display_preempt_o, 1'h1);
        chk(fr_high_o, 1'h1);
        wb(1'h0, REG_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_3061);
        wb(1'h1, REG_MSG, 32'h0000_0011);
        chk(display_preempt_o, 1'h0);
        test_sw_i <= 1'h0;
        wt(1, 1'h1);
        test_sw_i <= 1'h1;
        repeat (40) @(posedge clock_i);
        chk({main_valve_o, pilot_valve_o, spark_o}, 3'h3);
        flame_en_i <= 1'h0;
        wt(3, 1'h1);
        rng(n, 30, 35);
        test_sw_i <= 1'h0;
        demand_i <= 1'h0;
        flame_en_i <= 1'h1;
        wb(1'h1, REG_CTRL, 32'h0000_0204);
    endtask : s_test
    task automatic test_done;
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    initial begin
        repeat (8) @(posedge clock_i);
        sys_rst_i <= 1'h0;
        s_regs;
        s_fire(2'h0, 15, 1'h0);
        s_fire(2'h1, 10, 1'h1);
        s_fire(2'h2, 10, 1'h1);
        s_fire(2'h3, 10, 1'h1);
        pilot_valve_mode_jumper_i <= 1'h1;
        s_fire(2'h1, 15, 1'h0);
        blower_wire_i <= 1'h1;
        s_fire(2'h1, 30, 1'h0);
        s_test;
        s_faults;
        test_done;
    end
    // watchdog, far beyond the hundred to hundred and fifty cycles each cycle takes
    initial begin
        repeat (5000) @(posedge clock_i);
        errors++;
        test_done;
    end
endmodule : tb

// [verilog/bis_sequencer.sv]
// burner ignition, run and postpurge sequencer with wishbone registers
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps

module bis_sequencer #(
    parameter int unsigned TICK_CYCLES = bis_pkg::SEC_TICK_CYCLES
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // field inputs, high = closed / present / test / clipped / fitted
    input wire logic demand_i,
    input wire logic preign_ilk_i,
    input wire logic high_fire_sw_i,
    input wire logic low_fire_sw_i,
    input wire logic flame_i,
    input wire logic test_sw_i,
    input wire logic pilot_period_jumper_i,
    input wire logic pilot_valve_mode_jumper_i,
    input wire logic blower_wire_i,
    input wire logic valve_term_jumpered_i,
    // field outputs
    output logic pilot_valve_o,
    output logic pilot_ign_o,
    output logic spark_o,
    output logic main_valve_o,
    output logic blower_o,
    output logic fr_high_o,
    output logic fr_low_o,
    output logic fr_release_o,
    output logic damper_o,
    output logic lockout_o,
    output logic display_preempt_o
);
    import bis_pkg::*;

    typedef struct packed {
        bis_state_t st;
        logic [7:0] sec;
        logic [7:0] flameout;
        logic pilot;
        logic ign;
        logic spark;
        logic main;
        logic blower;
        logic fr_high;
        logic fr_low;
        logic fr_release;
        logic damper;
        logic lockout;
        logic hold;
        bis_variant_t variant;
        logic [7:0] purge_secs;
        logic [7:0] msg_sel;
        logic [7:0] msg_age;
        logic preempt;
        logic ack;
        logic [31:0] dat;
    } bis_seq_state_t;

    bis_seq_state_t r;
    bis_seq_state_t n;
    logic tick;
    logic fault;
    logic req;
    logic wr_ctrl;
    logic wr_msg;
    logic [7:0] sec_inc;
    logic [7:0] pilot_len;
    logic [7:0] test_lim;
    logic [7:0] main_establish_period_len;
    logic pilot_interrupted;
    logic test_ignored;
    logic prepurge_hold;

    // ----------------------------------------------------------------
    // seconds tick
    // ----------------------------------------------------------------
    bis_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .tick_o(tick)
    );

    // ----------------------------------------------------------------
    // configuration derived terms
    // ----------------------------------------------------------------
    // pilot period length from jumper
    assign pilot_len = pilot_period_jumper_i ? T_PILOT_SHORT_S : T_PILOT_LONG_S;
    assign test_lim = pilot_period_jumper_i ? T_TEST_LIM_SHORT_S : T_TEST_LIM_LONG_S;
    // jumpered valve terminals defeat the pilot test hold, in the lockout variant only
    assign test_ignored = (r.variant == VAR_LOCKOUT) & valve_term_jumpered_i;
    // lockout variants always interrupt the pilot
    assign pilot_interrupted = (r.variant == VAR_LOCKOUT) |
                               ((r.variant == VAR_CONFIG) & pilot_valve_mode_jumper_i);

    // main period runs until the interrupted pilot drops
    always_comb begin
        main_establish_period_len = T_IGN_OFF_S;
        if (r.variant == VAR_LOCKOUT) begin
            main_establish_period_len = T_PILOT_INT_S;
        end else if (r.variant == VAR_CONFIG && pilot_valve_mode_jumper_i) begin
            // extra wire stretches the interrupted pilot
            main_establish_period_len = blower_wire_i ? T_PILOT_INT_EXT_S : T_PILOT_INT_S;
        end
    end

    // seconds counter saturates instead of wrapping
    assign sec_inc = (tick && r.sec != SEC_MAX) ? 8'(r.sec + 8'h01) : r.sec;
    assign prepurge_hold = test_sw_i & ((r.st == ST_PP_HIGH) | (r.st == ST_PP_TIMED) | (r.st == ST_PP_LOW));

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // ack comes one cycle after the request and drops the cycle after
    assign req = wb_cyc_i & wb_stb_i & ~r.ack;
    assign wr_ctrl = req & wb_we_i & (wb_adr_i[7:2] == REG_CTRL[7:2]);
    assign wr_msg = req & wb_we_i & (wb_adr_i[7:2] == REG_MSG[7:2]) & wb_sel_i[0];

    // ----------------------------------------------------------------
    // sequence, timers and registers
    // ----------------------------------------------------------------
    always_comb begin
        n = r;
        fault = 1'b0;
        n.ack = req;
        n.dat = 32'h0000_0000;
        n.hold = 1'b0;
        case (r.st)
            ST_STANDBY: begin
                n.sec = 8'h00;
                // lockout latch keeps the burner down until software clears it
                if (demand_i && preign_ilk_i && !r.lockout) begin
                    n.st = ST_PP_HIGH;
                    n.blower = 1'b1;
                    n.fr_high = 1'b1;
                end
            end
            ST_PP_HIGH, ST_PP_TIMED, ST_PP_LOW: begin
                if (!demand_i) begin
                    n.st = ST_STANDBY;
                    n.blower = 1'b0;
                    n.fr_high = 1'b0;
                    n.fr_low = 1'b0;
                end else if (!preign_ilk_i) begin
                    // lockout variants shut down, others recycle to standby
                    if (r.variant == VAR_LOCKOUT) begin
                        fault = 1'b1;
                    end else begin
                        n.st = ST_STANDBY;
                        n.blower = 1'b0;
                        n.fr_high = 1'b0;
                        n.fr_low = 1'b0;
                    end
                end else if (r.st == ST_PP_HIGH) begin
                    n.hold = test_sw_i;
                    // the high-fire purge hold waits here until the switch is back at run
                    if (high_fire_sw_i && !test_sw_i) begin
                        n.st = ST_PP_TIMED;
                        n.sec = 8'h00;
                    end
                end else if (r.st == ST_PP_TIMED) begin
                    n.hold = test_sw_i;
                    if (!test_sw_i) begin
                        n.sec = sec_inc;
                    end
                    if (r.sec >= r.purge_secs) begin
                        n.st = ST_PP_LOW;
                        n.fr_high = 1'b0;
                        n.fr_low = 1'b1;
                    end
                end else begin
                    n.hold = test_sw_i;
                    // low fire proven before the ignition trial
                    if (low_fire_sw_i && !test_sw_i) begin
                        n.st = ST_PILOT;
                        n.sec = 8'h00;
                        n.flameout = 8'h00;
                        // pilot and both ignition outputs together
                        n.pilot = 1'b1;
                        n.ign = 1'b1;
                        n.spark = 1'b1;
                    end
                end
            end
            ST_PILOT: begin
                // preignition interlock not looked at here
                if (!low_fire_sw_i) begin
                    fault = 1'b1;
                end else if (test_sw_i && !test_ignored && r.sec < test_lim) begin
                    // timer stopped; flameout timer guards the hold
                    n.hold = 1'b1;
                    if (flame_i) begin
                        n.flameout = 8'h00;
                    end else if (tick) begin
                        n.flameout = 8'(r.flameout + 8'h01);
                    end
                    if (r.flameout >= T_FLAMEOUT_S) begin
                        fault = 1'b1;
                    end
                end else begin
                    n.sec = sec_inc;
                    n.flameout = 8'h00;
                    if (r.sec >= T_SPARK_OFF_S) begin
                        n.spark = 1'b0;
                    end
                    if (r.sec >= pilot_len) begin
                        // main valve only with flame proven
                        if (flame_i) begin
                            n.st = ST_MAIN;
                            n.sec = 8'h00;
                            n.main = 1'b1;
                            n.spark = 1'b0;
                        end else begin
                            // no flame at pilot period end
                            fault = 1'b1;
                        end
                    end
                end
            end
            ST_MAIN: begin
                n.sec = sec_inc;
                if (!low_fire_sw_i) begin
                    fault = 1'b1;
                end
                // combined pilot/ignition drops ten seconds in
                if (r.sec >= T_IGN_OFF_S) begin
                    n.ign = 1'b0;
                end
                if (r.sec >= main_establish_period_len) begin
                    if (flame_i) begin
                        n.st = ST_RUN;
                        n.sec = 8'h00;
                        n.ign = 1'b0;
                        if (pilot_interrupted) begin
                            n.pilot = 1'b0;
                        end
                    end else begin
                        // no flame at main period end
                        fault = 1'b1;
                    end
                end
            end
            ST_RUN: begin
                n.sec = sec_inc;
                if (!flame_i) begin
                    fault = 1'b1;
                end
                if (r.sec >= T_STAB_S) begin
                    // release or damper, depending on variant
                    n.fr_release = (r.variant != VAR_ONOFF) & ~test_sw_i;
                    n.damper = (r.variant == VAR_ONOFF);
                end
                // test drives firing rate to low fire
                n.fr_low = test_sw_i;
                if (test_sw_i) begin
                    n.fr_release = 1'b0;
                end
                // run lasts until the controller input opens
                if (!demand_i) begin
                    // postpurge start: valves off, low fire
                    n.st = ST_POSTPURGE;
                    n.sec = 8'h00;
                    n.main = 1'b0;
                    n.pilot = 1'b0;
                    n.fr_release = 1'b0;
                    n.damper = 1'b0;
                    n.fr_low = 1'b1;
                end
            end
            ST_POSTPURGE: begin
                n.sec = sec_inc;
                n.blower = 1'b1;
                if (r.sec >= T_PREIGN_CLOSE_S && !preign_ilk_i) begin
                    fault = 1'b1;
                end else if (r.sec >= T_POSTPURGE_S) begin
                    n.st = ST_STANDBY;
                    n.blower = 1'b0;
                    n.fr_low = 1'b0;
                end
            end
            ST_LOCKOUT: begin
                // only a software reset leaves lockout
                if (wr_ctrl && wb_sel_i[0] && wb_dat_i[CTRL_RST_BIT]) begin
                    n.st = ST_STANDBY;
                    n.lockout = 1'b0;
                end
            end
            default: begin
                fault = 1'b1;
            end
        endcase

        // pilot or main demand loss ends in postpurge
        if ((r.st == ST_PILOT || r.st == ST_MAIN) && !demand_i && !fault) begin
            n.st = ST_POSTPURGE;
            n.sec = 8'h00;
            n.main = 1'b0;
            n.pilot = 1'b0;
            n.ign = 1'b0;
            n.spark = 1'b0;
            n.fr_low = 1'b1;
        end

        if (fault) begin
            n.st = ST_LOCKOUT;
            n.lockout = 1'b1;
            n.pilot = 1'b0;
            n.ign = 1'b0;
            n.spark = 1'b0;
            n.main = 1'b0;
            n.blower = 1'b0;
            n.fr_high = 1'b0;
            n.fr_low = 1'b0;
            n.fr_release = 1'b0;
            n.damper = 1'b0;
        end

        // preemption after 60 s of pending message
        if (wr_msg) begin
            n.msg_sel = wb_dat_i[7:0];
            n.msg_age = 8'h00;
            // a preemption falling due in the write cycle is not lost
            n.preempt = (r.lockout | r.hold) & ~r.preempt & (r.msg_age >= T_PREEMPT_S);
        end else if (r.lockout || r.hold) begin
            if (tick && r.msg_age != SEC_MAX) begin
                n.msg_age = 8'(r.msg_age + 8'h01);
            end
            if (r.msg_age >= T_PREEMPT_S) begin
                n.preempt = 1'b1;
            end
        end else begin
            n.msg_age = 8'h00;
            n.preempt = 1'b0;
        end

        // control register writes honour byte lanes
        if (wr_ctrl) begin
            if (wb_sel_i[0]) begin
                n.variant = bis_variant_t'(wb_dat_i[CTRL_VAR_LSB +: 2]);
            end
            if (wb_sel_i[1]) begin
                n.purge_secs = wb_dat_i[CTRL_PURGE_LSB +: 8];
            end
        end

        // read data; unmapped words read as zero
        if (req && !wb_we_i) begin
            case (wb_adr_i[7:2])
                REG_CTRL[7:2]: begin
                    n.dat[CTRL_VAR_LSB +: 2] = r.variant;
                    n.dat[CTRL_PURGE_LSB +: 8] = r.purge_secs;
                end
                REG_STATUS[7:2]: begin
                    n.dat[STAT_STATE_LSB +: 4] = r.st;
                    n.dat[STAT_LOCK_BIT] = r.lockout;
                    n.dat[STAT_PREEMPT_BIT] = r.preempt;
                    n.dat[STAT_HOLD_BIT] = r.hold | prepurge_hold;
                    n.dat[STAT_OUT_LSB +: 9] = {r.damper, r.fr_release, r.fr_low, r.fr_high,
                                                r.blower, r.main, r.spark, r.ign, r.pilot};
                end
                REG_MSG[7:2]: begin
                    n.dat[7:0] = r.msg_sel;
                end
                default: begin
                    n.dat = 32'h0000_0000;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            r <= '0;
            r.st <= ST_STANDBY;
            r.variant <= VAR_RST;
            r.purge_secs <= PURGE_RST;
            r.msg_sel <= MSG_RST;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // fault gates fuel and ignition in the detecting cycle
    assign pilot_valve_o = r.pilot & ~fault;
    assign pilot_ign_o = r.ign & ~fault;
    assign spark_o = r.spark & ~fault;
    assign main_valve_o = r.main & ~fault;
    assign blower_o = r.blower;
    assign fr_high_o = r.fr_high;
    assign fr_low_o = r.fr_low;
    assign fr_release_o = r.fr_release;
    assign damper_o = r.damper;
    assign lockout_o = r.lockout;
    assign display_preempt_o = r.preempt;
    assign wb_dat_o = r.dat;
    assign wb_ack_o = r.ack;

endmodule : bis_sequencer

// [verilog/bis_tick_gen.sv]
// one-second tick generator for the sequence timers
`timescale 1ns/10ps

module bis_tick_gen #(
    parameter int unsigned TICK_CYCLES = bis_pkg::SEC_TICK_CYCLES
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    output logic tick_o
);
    import bis_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } bis_tick_state_t;

    bis_tick_state_t r;
    bis_tick_state_t n;

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------
    // tick is a one-cycle pulse every TICK_CYCLES edges
    always_comb begin
        n = r;
        n.tick = 1'b0;
        if (r.cnt >= 32'(TICK_CYCLES - 1)) begin
            n.cnt = 32'h0000_0000;
            n.tick = 1'b1;
        end else begin
            n.cnt = r.cnt + 32'h0000_0001;
        end
    end

    // state register
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick_o = r.tick;

endmodule : bis_tick_gen
